// file: rtl/tsm_map.svh
// address map, field positions, reset values and sizes of the segment/page translation unit
`ifndef TSM_MAP_SVH
`define TSM_MAP_SVH

// ==========================================================================
// geometry
`define TSM_PAGE_BYTES     2048
`define TSM_SEG_BYTES      32768
`define TSM_NUM_CTX        16
`define TSM_CTX_BITS       4
`define TSM_SEG_PER_CTX    64
`define TSM_TABLE_ENTRIES  1024
`define TSM_LA_BITS        21
`define TSM_PA_BITS        23
`define TSM_PPN_BITS       12
`define TSM_LA_SEG_LSB     15
`define TSM_LA_PAGE_LSB    11

// ==========================================================================
// software address map (byte addresses)
`define TSM_PAGE_BASE      24'hA00000
`define TSM_PAGE_LAST      24'hBFFFFF
`define TSM_SEG_BASE       24'hC00000
`define TSM_SEG_LAST       24'hDFFFFF
`define TSM_CTX_ADDR       24'hF00000
`define TSM_LUT_BASE       24'hF00100

// ==========================================================================
// field positions inside the 16-bit entry words
`define TSM_CTX_LSB        12
`define TSM_SEG_PROT_LSB   8
`define TSM_SEG_VIRT_LSB   0

// ==========================================================================
// reset values
`define TSM_CTX_RESET      4'h0
`define TSM_SEG_RESET      10'h000
`define TSM_PAGE_RESET     16'h3000
`define TSM_LUT_RESET      {{7{6'h3F}}, 6'h19, {7{6'h3F}}, 6'h00}

`endif

// file: rtl/tsm_pkg.sv
// types shared by the segment/page translation unit
`include "tsm_map.svh"
package tsm_pkg;

  // ========================================================================
  // table entries
  typedef enum logic [1:0] {
    TSM_ONBOARD_MEM,
    TSM_OFFBOARD_MEM,
    TSM_OFFBOARD_IO,
    TSM_NO_PAGE
  } tsm_space_t;

  typedef struct packed {
    logic [3:0] prot;
    logic [5:0] virt;
  } tsm_seg_t;

  typedef struct packed {
    logic                     dirty;
    logic                     used;
    tsm_space_t               space;
    logic [`TSM_PPN_BITS-1:0] ppn;
  } tsm_page_t;

  // rights bits: user x/w/r, supervisor x/w/r
  typedef struct packed {
    logic usr_x;
    logic usr_w;
    logic usr_r;
    logic sup_x;
    logic sup_w;
    logic sup_r;
  } tsm_rights_t;

  // ========================================================================
  // processor side
  typedef struct packed {
    logic                    valid;
    logic                    supv;
    logic                    write;
    logic                    exec;
    logic [`TSM_LA_BITS-1:0] laddr;
  } tsm_cpu_req_t;

  typedef struct packed {
    logic                    valid;
    logic                    grant;
    logic                    abort_prot;
    logic                    abort_inval;
    tsm_space_t              space;
    logic [`TSM_PA_BITS-1:0] paddr;
  } tsm_xlat_t;

  // ========================================================================
  // register bus
  typedef enum logic [1:0] {TSM_B_IDLE, TSM_B_WRITE, TSM_B_WDONE} tsm_bus_state_t;
  typedef enum logic [2:0] {TSM_T_NONE, TSM_T_CTX, TSM_T_SEG, TSM_T_PAGE, TSM_T_LUT} tsm_kind_t;

  typedef struct packed {
    tsm_kind_t  kind;
    logic [9:0] idx;
  } tsm_target_t;

  typedef struct packed {
    logic [15:0][5:0] ent;
  } tsm_lut_state_t;

  typedef struct packed {
    tsm_bus_state_t                        bstate;
    tsm_target_t                           tgt;
    logic [`TSM_CTX_BITS-1:0]              ctx;
    tsm_seg_t [`TSM_TABLE_ENTRIES-1:0]     seg;
    tsm_page_t [`TSM_TABLE_ENTRIES-1:0]    page;
    logic [31:0]                           rdata;
    tsm_xlat_t                             res;
  } tsm_mmu_state_t;

endpackage

// file: rtl/tsm_prot_lut.sv
// protection class lookup: code to rights, with a software write port
`timescale 1ns/1ps
`include "tsm_map.svh"
module tsm_prot_lut (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_idx,
  input  wire logic [5:0] wr_data,
  input  wire logic [3:0] rd_idx,
  output logic      [5:0] rd_data,
  input  wire logic [3:0] chk_code,
  input  wire logic       chk_super,
  input  wire logic       chk_write,
  input  wire logic       chk_exec,
  output logic            allow
);

  // ==========================================================================
  // state
  tsm_pkg::tsm_lut_state_t r;
  tsm_pkg::tsm_lut_state_t next_r;
  tsm_pkg::tsm_rights_t    rt;

  always_comb begin
    next_r = r;
    if (wr_en) begin
      next_r.ent[wr_idx] = wr_data; // [R23]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.ent <= `TSM_LUT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // rights check, same for both privilege states and every segment
  assign rd_data = r.ent[rd_idx];
  assign rt      = tsm_pkg::tsm_rights_t'(r.ent[chk_code]); // [R6] [R7]

  always_comb begin
    if (chk_super) begin
      allow = chk_write ? rt.sup_w : (chk_exec ? rt.sup_x : rt.sup_r);
    end else begin
      allow = chk_write ? rt.usr_w : (chk_exec ? rt.usr_x : rt.usr_r);
    end
  end

  // ==========================================================================
  // checks
  a_lut_sup_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
    chk_super && chk_write |-> allow == r.ent[chk_code][1])
    else $error("supervisor write right mismatch");
  a_lut_usr_exec: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
    !chk_super && !chk_write && chk_exec |-> allow == r.ent[chk_code][5])
    else $error("user execute right mismatch");
  a_lut_write_load: assert property (@(posedge hclk) disable iff (!hresetn) // [R23]
    wr_en |=> r.ent[$past(wr_idx)] == $past(wr_data))
    else $error("protection class not loaded");

endmodule // tsm_prot_lut

// file: rtl/tsm_mmu.sv
// two-level segment/page translation unit with its register slave
`timescale 1ns/1ps
`include "tsm_map.svh"

// Operation
// [R1] 2 KB pages, 32 KB segments, 16 contexts
// [R2] 1024 page and 1024 segment entries shared
// [R3] segment table first, then page table
// [R4] translation and check within one cycle
// [R5] memory and I/O accesses translated alike
// [R6] 16 classes, separate r/w/x per state
// [R7] check same for both states, all segments
// [R8] context selects table portion immediately
// [R9] context write takes data bits 15..12
// [R10] segment index is context plus top six
// [R11] segment entry gives six virtual, four protection
// [R12] page invalidation or chaining resizes segments
// [R13] segment entries at 32 KB stride from base
// [R14] page index is virtual plus four bits
// [R15] twelve page bits plus eleven offset bits
// [R16] page entry marks and steers address space
// [R17] non-existent page aborts the access
// [R18] software loads consistent table entries
// [R19] used on grant, dirty on granted write
// [R20] page table at A00000 to BFFFFF
// [R21] contexts private, sharing via virtual blocks
// [R22] denied access aborts, no side effects
// [R23] protection classes held in loadable lookup
module tsm_mmu (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic                       hreadyout,
  output logic      [31:0]           hrdata,
  output logic                       hresp,
  input  wire tsm_pkg::tsm_cpu_req_t cpu_req,
  output tsm_pkg::tsm_xlat_t         xlat
);

  // ==========================================================================
  // state
  tsm_pkg::tsm_mmu_state_t r;
  tsm_pkg::tsm_mmu_state_t next_r;

  // ==========================================================================
  // address decode, used for both the read path and the write capture
  function automatic tsm_pkg::tsm_target_t decode(input logic [31:0] a,
                                                  input logic [3:0]  ctx,
                                                  input logic [2:0]  size);
    tsm_pkg::tsm_target_t d;
    d.kind = tsm_pkg::TSM_T_NONE;
    d.idx  = 10'h000;
    if (a[31:24] == 8'h00 && a[1:0] == 2'b00 && size == 3'b010) begin
      if (a[23:0] >= `TSM_PAGE_BASE && a[23:0] <= `TSM_PAGE_LAST && a[10:2] == 9'h000) begin
        d.kind = tsm_pkg::TSM_T_PAGE; // [R20]
        d.idx  = a[20:11];
      end else if (a[23:0] >= `TSM_SEG_BASE && a[23:0] <= `TSM_SEG_LAST && a[14:2] == 13'h0000) begin
        d.kind = tsm_pkg::TSM_T_SEG; // [R13]
        d.idx  = {ctx, a[20:15]};
      end else if (a[23:0] == `TSM_CTX_ADDR) begin
        d.kind = tsm_pkg::TSM_T_CTX;
      end else if (a[23:6] == 18'(`TSM_LUT_BASE >> 6)) begin
        d.kind = tsm_pkg::TSM_T_LUT;
        d.idx  = {6'h00, a[5:2]};
      end
    end
    return d;
  endfunction

  function automatic logic [31:0] seg_word(input tsm_pkg::tsm_seg_t s);
    return {20'h00000, s.prot, 2'b00, s.virt}; // [R13]
  endfunction

  // ==========================================================================
  // translation path, purely combinational from the sampled request
  logic [9:0]            sidx;
  tsm_pkg::tsm_seg_t     se;
  logic [9:0]            pidx;
  tsm_pkg::tsm_page_t    pe;
  logic                  allow;
  logic                  inval;
  logic                  grant;

  assign sidx  = {r.ctx, cpu_req.laddr[20:`TSM_LA_SEG_LSB]};  // [R10] [R8] [R21] [R2]
  assign se    = r.seg[sidx];                                // [R3] [R11]
  assign pidx  = {se.virt, cpu_req.laddr[14:`TSM_LA_PAGE_LSB]}; // [R14] [R12] [R1]
  assign pe    = r.page[pidx];                               // [R3]
  assign inval = (pe.space == tsm_pkg::TSM_NO_PAGE);          // [R17] [R12]
  // one access kind for memory and I/O alike: the page entry decides the space
  assign grant = cpu_req.valid && allow && !inval;           // [R5] [R22]

  // ==========================================================================
  // register bus decode
  logic                   accept;
  tsm_pkg::tsm_target_t   dec;
  logic                   wr_commit;
  logic                   sw_page_wr;
  logic                   sw_lut_wr;
  logic [5:0]             lut_rd;
  logic [31:0]            rd_val;

  assign accept     = hsel && htrans[1] && hready && (r.bstate != tsm_pkg::TSM_B_WRITE);
  assign dec        = decode(haddr, r.ctx, hsize);
  assign wr_commit  = (r.bstate == tsm_pkg::TSM_B_WRITE);
  assign sw_page_wr = wr_commit && (r.tgt.kind == tsm_pkg::TSM_T_PAGE);
  assign sw_lut_wr  = wr_commit && (r.tgt.kind == tsm_pkg::TSM_T_LUT);

  tsm_prot_lut u_lut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .wr_en     (sw_lut_wr),
    .wr_idx    (r.tgt.idx[3:0]),
    .wr_data   (hwdata[5:0]),
    .rd_idx    (dec.idx[3:0]),
    .rd_data   (lut_rd),
    .chk_code  (se.prot),
    .chk_super (cpu_req.supv),
    .chk_write (cpu_req.write),
    .chk_exec  (cpu_req.exec),
    .allow     (allow)
  ); // [R6] [R23]

  always_comb begin
    case (dec.kind)
      tsm_pkg::TSM_T_PAGE: rd_val = {16'h0000, r.page[dec.idx]};
      tsm_pkg::TSM_T_SEG:  rd_val = seg_word(r.seg[dec.idx]);
      tsm_pkg::TSM_T_CTX:  rd_val = {16'h0000, r.ctx, 12'h000};
      tsm_pkg::TSM_T_LUT:  rd_val = {26'h0000000, lut_rd};
      default:             rd_val = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_r = r;

    // result registered at the edge ending the request cycle
    next_r.res.valid       = cpu_req.valid;                         // [R4]
    next_r.res.grant       = grant;
    next_r.res.abort_prot  = cpu_req.valid && !allow;               // [R22]
    next_r.res.abort_inval = cpu_req.valid && inval;                // [R17]
    next_r.res.space       = pe.space;                              // [R16]
    next_r.res.paddr       = {pe.ppn, cpu_req.laddr[10:0]};         // [R15]

    // statistics only on granted cycles; a denied cycle leaves the entry alone
    if (grant) begin
      next_r.page[pidx].used = 1'b1;                                // [R19]
      if (cpu_req.write) begin
        next_r.page[pidx].dirty = 1'b1;                             // [R19]
      end
    end

    case (r.bstate)
      tsm_pkg::TSM_B_WRITE: begin
        // a granted access in the same cycle still marks the page it hits
        case (r.tgt.kind)
          tsm_pkg::TSM_T_CTX:  next_r.ctx = hwdata[15:`TSM_CTX_LSB];        // [R9] [R8]
          tsm_pkg::TSM_T_SEG:  begin
            next_r.seg[r.tgt.idx].prot = hwdata[11:`TSM_SEG_PROT_LSB];       // [R13]
            next_r.seg[r.tgt.idx].virt = hwdata[5:`TSM_SEG_VIRT_LSB];
          end
          tsm_pkg::TSM_T_PAGE: begin
            next_r.page[r.tgt.idx] = hwdata[15:0];                          // [R20]
            if (grant && pidx == r.tgt.idx) begin
              next_r.page[r.tgt.idx].used  = 1'b1;                          // [R19]
              next_r.page[r.tgt.idx].dirty = hwdata[15] | cpu_req.write;
            end
          end
          default:             next_r.ctx = r.ctx;
        endcase
        next_r.bstate = tsm_pkg::TSM_B_WDONE;
      end
      default: begin
        next_r.bstate = tsm_pkg::TSM_B_IDLE;
        if (accept) begin
          next_r.tgt = dec;
          if (hwrite) begin
            next_r.bstate = tsm_pkg::TSM_B_WRITE;
          end else begin
            next_r.rdata = rd_val;
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // registers; tables are flops, reset invalid so nothing maps before setup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.bstate   <= tsm_pkg::TSM_B_IDLE;
      r.tgt      <= '0;
      r.ctx      <= `TSM_CTX_RESET;
      r.seg      <= {`TSM_TABLE_ENTRIES{`TSM_SEG_RESET}};
      r.page     <= {`TSM_TABLE_ENTRIES{`TSM_PAGE_RESET}};
      r.rdata    <= 32'h00000000;
      r.res      <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  // write takes one wait state so a following read sees the new value
  assign hreadyout = (r.bstate != tsm_pkg::TSM_B_WRITE);
  assign hrdata    = r.rdata;
  assign hresp     = 1'b0;
  assign xlat      = r.res;

  // ==========================================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_ctx_load_bits: assert property ( // [R9]
    wr_commit && r.tgt.kind == tsm_pkg::TSM_T_CTX |=> r.ctx == $past(hwdata[15:12]))
    else $error("context not loaded from bits 15..12");

  a_ctx_held_stable: assert property ( // [R8]
    !(wr_commit && r.tgt.kind == tsm_pkg::TSM_T_CTX) |=> $stable(r.ctx))
    else $error("context changed without a write");

  a_paddr_offset_pass: assert property ( // [R15]
    cpu_req.valid |=> xlat.valid && xlat.paddr[10:0] == $past(cpu_req.laddr[10:0]))
    else $error("byte offset not passed through");

  a_paddr_page_map: assert property ( // [R14]
    cpu_req.valid |=> xlat.paddr[22:11] == $past(r.page[{r.seg[{r.ctx, cpu_req.laddr[20:15]}].virt,
                                                          cpu_req.laddr[14:11]}].ppn))
    else $error("physical page number not from two-step lookup");

  a_invalid_page_abort: assert property ( // [R17]
    cpu_req.valid && pe.space == tsm_pkg::TSM_NO_PAGE |=> xlat.abort_inval && !xlat.grant)
    else $error("non-existent page not aborted");

  a_prot_deny_abort: assert property ( // [R22]
    cpu_req.valid && !allow |=> xlat.abort_prot && !xlat.grant)
    else $error("denied access not aborted");

  a_used_bit_set: assert property ( // [R19]
    grant |=> r.page[$past(pidx)].used)
    else $error("used bit not set on granted access");

  a_dirty_read_clean: assert property ( // [R19]
    grant && !cpu_req.write && !pe.dirty && !sw_page_wr |=> !r.page[$past(pidx)].dirty)
    else $error("dirty bit set by a read");

  a_denied_no_update: assert property ( // [R22]
    cpu_req.valid && !grant && !sw_page_wr |=> r.page[$past(pidx)] == $past(pe))
    else $error("denied access changed page entry");

  a_write_wait_one: assert property (
    accept && hwrite |=> !hreadyout ##1 hreadyout)
    else $error("write wait state wrong");

  a_seg_write_load: assert property ( // [R13]
    wr_commit && r.tgt.kind == tsm_pkg::TSM_T_SEG
    |=> r.seg[$past(r.tgt.idx)] == {$past(hwdata[11:8]), $past(hwdata[5:0])})
    else $error("segment entry not loaded from write data");

  a_page_write_load: assert property ( // [R20]
    wr_commit && r.tgt.kind == tsm_pkg::TSM_T_PAGE && !grant
    |=> r.page[$past(r.tgt.idx)] == $past(hwdata[15:0]))
    else $error("page entry not loaded from write data");

  a_space_from_page: assert property ( // [R16]
    cpu_req.valid |=> xlat.space == $past(r.page[{r.seg[{r.ctx, cpu_req.laddr[20:15]}].virt,
                                                   cpu_req.laddr[14:11]}].space))
    else $error("address space not taken from page entry");

  a_idle_no_result: assert property ( // [R4]
    !cpu_req.valid |=> !xlat.valid && !xlat.grant)
    else $error("result shown without a request");

  a_grant_clean: assert property ( // [R22]
    xlat.grant |-> xlat.valid && !xlat.abort_prot && !xlat.abort_inval)
    else $error("granted access also flagged as aborted");

  a_dirty_on_write: assert property ( // [R19]
    grant && cpu_req.write |=> r.page[$past(pidx)].dirty)
    else $error("dirty bit not set on granted write");

  a_ctx_read_back: assert property ( // [R9]
    accept && !hwrite && dec.kind == tsm_pkg::TSM_T_CTX
    |=> hrdata == {16'h0000, $past(r.ctx), 12'h000})
    else $error("context read back wrong");

  a_read_data_held: assert property (
    !(accept && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_refused_read_zero: assert property (
    accept && !hwrite && dec.kind == tsm_pkg::TSM_T_NONE |=> hrdata == 32'h00000000)
    else $error("refused read returned data");

  c_granted_write: cover property (grant && cpu_req.write);
  c_invalid_abort: cover property (cpu_req.valid && inval);
  c_prot_abort: cover property (cpu_req.valid && !allow);
  c_ctx_switch_use: cover property (wr_commit && r.tgt.kind == tsm_pkg::TSM_T_CTX ##2 grant);
  c_page_read: cover property (accept && !hwrite && dec.kind == tsm_pkg::TSM_T_PAGE);

endmodule // tsm_mmu

// file: verification/tsm_cpu_model.sv
// processor core model issuing logical addresses to the translation unit
`timescale 1ns/1ps
module tsm_cpu_model (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  cmd_go,
  input  wire tsm_pkg::tsm_cpu_req_t cmd,
  output tsm_pkg::tsm_cpu_req_t      cpu_req
);
  // ==========================================
  // request driver
  // idle cycles scramble the address so a stale request never looks held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_req <= '0;
    end else if (cmd_go) begin
      cpu_req <= {1'b1, cmd.supv, cmd.write, cmd.exec, cmd.laddr};
    end else begin
      cpu_req.valid <= 1'b0;
      cpu_req.laddr <= ~cpu_req.laddr;
    end
  end
endmodule // tsm_cpu_model

// file: verification/tsm_mmu_bench.sv
// self-checking bench for the segment/page translation unit
`timescale 1ns/1ps
`include "tsm_map.svh"
module tsm_mmu_bench;
  // ==========================================
  // signals and shadow tables
  logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_go, rd_phase;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr, hwdata, hrdata, rng;
  tsm_pkg::tsm_cpu_req_t cmd, cpu_req;
  tsm_pkg::tsm_xlat_t    xlat;
  logic [9:0]            seg_sh [1024];
  logic [15:0]           page_sh [1024];
  logic [5:0]            lut_sh [16];
  logic [3:0]            ctx_sh;
  logic [31:0]           rq [$];
  tsm_pkg::tsm_xlat_t    xq [$];
  int                    n_mismatch, n_checks;

  tsm_mmu i_tsm_mmu (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cpu_req(cpu_req), .xlat(xlat));
  tsm_cpu_model i_tsm_cpu_model (.hclk(hclk), .hresetn(hresetn), .cmd_go(cmd_go), .cmd(cmd),
    .cpu_req(cpu_req));

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // expected result; shadow statistics only move on a granted valid page
  function automatic tsm_pkg::tsm_xlat_t exp_x(tsm_pkg::tsm_cpu_req_t q);
    tsm_pkg::tsm_xlat_t e;
    logic [9:0]         s;
    logic [9:0]         pi;
    logic [5:0]         r;
    logic               ok;
    s = seg_sh[{ctx_sh, q.laddr[20:15]}];
    pi = {s[5:0], q.laddr[14:11]};
    r = lut_sh[s[9:6]];
    ok = q.supv ? (q.write ? r[1] : q.exec ? r[2] : r[0]) : (q.write ? r[4] : q.exec ? r[5] : r[3]);
    e.valid = 1'b1;
    e.abort_prot = !ok;
    e.abort_inval = (page_sh[pi][13:12] == 2'b11);
    e.grant = ok && !e.abort_inval;
    e.space = tsm_pkg::tsm_space_t'(page_sh[pi][13:12]);
    e.paddr = {page_sh[pi][11:0], q.laddr[10:0]};
    if (e.grant) begin
      page_sh[pi][14] = 1'b1;
      page_sh[pi][15] = page_sh[pi][15] | q.write;
    end
    return e;
  endfunction

  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // address and space only matter on a granted access
  task automatic cmp_x(input tsm_pkg::tsm_xlat_t g, input tsm_pkg::tsm_xlat_t e);
    tsm_pkg::tsm_xlat_t m;
    m = g;
    if (e.grant !== 1'b1) begin
      m.space = e.space;
      m.paddr = e.paddr;
    end
    cmp_rd({4'h0, m}, {4'h0, e});
  endtask

  // ready sampled mid-cycle so the edge's own update never races the test
  task automatic wait_rdy();
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask

  // entered just after a rising edge; for a read d is the expected data
  task automatic bus(input logic wr, input logic [2:0] sz, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    if (!wr) begin
      rq.push_back(d);
      rd_phase <= 1'b1;
    end
    wait_rdy();
    rd_phase <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, 3'b010, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, 3'b010, a, e);
  endtask

  task automatic close_out();
    n_mismatch += xq.size() + rq.size();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================
  // monitor
  always @(negedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) cmp_rd(hrdata, rq.pop_front());
    if (rd_phase && hreadyout === 1'b1) cmp_rd({31'h0, hresp}, 32'h0);
    if (xlat.valid === 1'b1) cmp_x(xlat, xq.pop_front());
  end

  // ==========================================
  // clock, watchdog, tests
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    #(25 * 20000);
    n_mismatch++;
    close_out();
  end

  initial begin
    tsm_pkg::tsm_cpu_req_t q;
    logic                  go;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    cmd_go = 1'b0;
    cmd = '0;
    rd_phase = 1'b0;
    rng = 32'h0000_0040;
    ctx_sh = 4'h0;
    for (int i = 0; i < 1024; i++) begin
      seg_sh[i] = 10'h000;
      page_sh[i] = 16'h3000;
    end
    for (int i = 0; i < 16; i++) lut_sh[i] = (i == 0) ? 6'h00 : (i == 8) ? 6'h19 : 6'h3F;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`TSM_CTX_ADDR, 32'h0);
    rd(`TSM_SEG_BASE, 32'h0);
    rd(`TSM_PAGE_BASE + 32'h800 * 1023, 32'h0000_3000);
    for (int c = 0; c < 16; c++) rd(`TSM_LUT_BASE + 4 * c, {26'h0, lut_sh[c]});
    $display("test reset done");
    wr(`TSM_CTX_ADDR, 32'hFFFF_AFFF);
    bus(1'b1, 3'b000, `TSM_CTX_ADDR, 32'h0000_3000);
    wr(32'h01F0_0000, 32'h0000_5000);
    wr(`TSM_SEG_BASE + 4, 32'h0000_0F3F);
    rd(`TSM_CTX_ADDR, 32'h0000_A000);
    rd(`TSM_SEG_BASE + 4, 32'h0);
    rd(32'h00F0_0004, 32'h0);
    bus(1'b0, 3'b001, `TSM_CTX_ADDR, 32'h0);
    $display("test refuse done");
    // tables loaded by software must match the board
    for (int i = 0; i < 16; i++) begin
      lut_sh[i] = 6'(rnd());
      wr(`TSM_LUT_BASE + 4 * i, {26'h0, lut_sh[i]});
    end
    for (int i = 0; i < 64; i++) begin
      page_sh[i] = 16'(rnd() & 32'h0000_3FFF);
      wr(`TSM_PAGE_BASE + 32'h800 * i, {16'h0, page_sh[i]});
    end
    // few virtual blocks so contexts share pages
    for (int c = 0; c < 16; c += 15) begin
      ctx_sh = 4'(c);
      wr(`TSM_CTX_ADDR, {16'h0, ctx_sh, 12'h000});
      for (int s = 0; s < 4; s++) begin
        seg_sh[{ctx_sh, 6'(s)}] = 10'(rnd()) & 10'h3C3;
        wr(`TSM_SEG_BASE + 32'h8000 * s, {20'h0, seg_sh[{ctx_sh, 6'(s)}][9:6], 2'b00,
          seg_sh[{ctx_sh, 6'(s)}][5:0]});
      end
    end
    $display("test load done");
    for (int c = 0; c < 16; c += 15) begin
      ctx_sh = 4'(c);
      wr(`TSM_CTX_ADDR, {16'h0, ctx_sh, 12'h000});
      rd(`TSM_SEG_BASE + 32'h8000, {20'h0, seg_sh[{ctx_sh, 6'd1}][9:6], 2'b00, seg_sh[{ctx_sh, 6'd1}][5:0]});
      for (int n = 0; n < 80; n++) begin
        q = tsm_pkg::tsm_cpu_req_t'({1'b1, 3'(rnd()), 21'(rnd() & 32'h0001_FFFF)});
        go = (rnd() & 32'h3) != 32'h0;
        cmd <= q;
        cmd_go <= go;
        if (go) xq.push_back(exp_x(q));
        @(posedge hclk);
      end
      cmd_go <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    $display("test translate done");
    for (int i = 0; i < 64; i++) rd(`TSM_PAGE_BASE + 32'h800 * i, {16'h0, page_sh[i]});
    $display("test statistics done");
    close_out();
  end
endmodule // tsm_mmu_bench
